// *** ftx_frame_trig.sv ***
// Frame start trigger, exposure timing and readout sequencing
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (R1) Trigger taken from selected line when enabled
// (R2) Host sets general line direction to input
// (R3) Rising or falling active edge selectable
// (R4) Timed and pulse-length exposure kinds
// (R5) Timed exposure lasts programmed duration
// (R6) Raw values count one microsecond units
// (R7) Internal frame period off leaves trigger rate
// (R8) Host sets acquisition start off, frame on
// (R9) Programmed exposure used unless pulse-length kind
// (R10) Exposure limited to 24 through 2500000 us
// (R11) Manual exposure only applies with auto off
// (R12) Host writes exposure in one microsecond steps
// (R13) Exposure then readout for every frame
// (R14) New exposure may overlap previous readout
// (R15) Overlap arises from timing, no setting
// (R16) Host keeps pulse until readout done
// (R17) Early pulse end drops frame, flags error
// (R18) Pulse-length exposure spans active pulse
// (R19) Triggers ignored unless waiting for trigger
// (R20) Trigger delay 0 to 10000000 us
// (R21) Wait status reads one when ready
// (R22) Microsecond tick counter, clamped exposure
//////////////////////////////////////////////////////////////////////////////
module ftx_frame_trig
  import ftx_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Trigger inputs
  input  wire logic        gp_line_in,
  input  wire logic        gp_line_direction,
  input  wire logic        cc1_in,
  input  wire logic        cc2_in,
  input  wire logic        cc3_in,
  // Acquisition outputs
  output logic             exposure_active,
  output logic             readout_active,
  output logic             frame_trig_wait,
  output logic             over_trigger_err,
  output logic             frame_dropped
);

  logic [31:0] ctrl_r;
  logic [31:0] exp_r;
  logic [31:0] delay_r;
  logic [31:0] readout_r;
  logic        ovt_sticky_r;
  logic        drop_sticky_r;
  logic        trig_r;
  ftx_state_t  state_r;
  logic [31:0] cnt_r;
  logic [31:0] ro_cnt_r;
  logic        tick;
  logic        restart;

  logic        frame_trig_enable;
  ftx_src_t    frame_trig_input_select;
  logic        frame_trig_edge_select;
  logic        exposure_kind_select;
  logic [7:0]  tick_gap_r;
  logic        trig_level;
  logic        edge_on;
  logic        edge_off;
  logic        exp_done;

  // Clamp a written exposure to the allowed window
  function automatic logic [31:0] clamp_exp(input logic [31:0] v);
    if (v < FTX_EXP_MIN_US)
      return FTX_EXP_MIN_US;
    else if (v > FTX_EXP_MAX_US)
      return FTX_EXP_MAX_US;
    else
      return v;
  endfunction

  assign frame_trig_enable        = ctrl_r[FTX_CTL_TRIG_EN];
  assign frame_trig_input_select  = ftx_src_t'(ctrl_r[FTX_CTL_SRC_LSB +: 2]);
  assign frame_trig_edge_select   = ctrl_r[FTX_CTL_EDGE_FALL];
  assign exposure_kind_select     = ctrl_r[FTX_CTL_KIND_WIDTH];

  //////////////////////////////////////////////////////////////////////////////
  // Trigger source and edge

  always_comb begin
    case (frame_trig_input_select) // [R1]
      FTX_SRC_LINE1: trig_level = gp_line_in & ~gp_line_direction; // [R2]
      FTX_SRC_CC1:   trig_level = cc1_in;
      FTX_SRC_CC2:   trig_level = cc2_in;
      FTX_SRC_CC3:   trig_level = cc3_in;
      default:       trig_level = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      trig_r <= 1'b0;
    else
      trig_r <= trig_level;
  end

  // Polarity folded in so active edge looks like a rise
  assign edge_on  = frame_trig_enable &
                    (frame_trig_edge_select ? (trig_r & ~trig_level)
                                            : (~trig_r & trig_level)); // [R3]
  assign edge_off = frame_trig_edge_select ? (~trig_r & trig_level)
                                           : (trig_r & ~trig_level);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r    <= FTX_CTRL_RST;
      exp_r     <= FTX_EXPOSURE_RST;
      delay_r   <= FTX_DELAY_RST;
      readout_r <= FTX_READOUT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        FTX_REG_CTRL:     ctrl_r <= {25'h0000000, reg_wdata[6:0]}; // [R7]
        FTX_REG_EXPOSURE: begin
          // Writes are ignored and the value is kept while the auto exposure bit is set
          if (!ctrl_r[FTX_CTL_AUTO_EXP])
            exp_r <= clamp_exp(reg_wdata); // [R10] [R11] [R22]
        end
        FTX_REG_DELAY:    delay_r <= (reg_wdata > FTX_DELAY_MAX_US) ?
                                     FTX_DELAY_MAX_US : reg_wdata; // [R20]
        FTX_REG_READOUT:  readout_r <= (reg_wdata == 32'h00000000) ?
                                       32'h00000001 : reg_wdata;
        default:          ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        FTX_REG_CTRL:     reg_rdata <= ctrl_r;
        FTX_REG_EXPOSURE: reg_rdata <= exp_r;
        FTX_REG_DELAY:    reg_rdata <= delay_r;
        FTX_REG_READOUT:  reg_rdata <= readout_r;
        FTX_REG_STATUS:   reg_rdata <= {27'h0000000, drop_sticky_r, ovt_sticky_r,
                                        readout_active, exposure_active,
                                        frame_trig_wait}; // [R21]
        default:          reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Acquisition sequencer

  ftx_us_tick u_tick (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .restart (restart),
    .tick    (tick)
  );

  assign restart  = (state_r == FTX_ST_WAIT) & edge_on;
  assign exp_done = tick & (cnt_r <= 32'h00000001);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r         <= FTX_ST_WAIT;
      cnt_r           <= 32'h00000000;
      exposure_active <= 1'b0;
      frame_trig_wait <= 1'b1;
    end else begin
      case (state_r)
        FTX_ST_WAIT: begin
          // Edges outside this state never start anything
          if (edge_on) begin // [R19]
            frame_trig_wait <= 1'b0;
            if (delay_r != 32'h00000000) begin
              state_r <= FTX_ST_DELAY; // [R20]
              cnt_r   <= delay_r;
            end else begin
              state_r         <= FTX_ST_EXPOSE;
              cnt_r           <= exp_r; // [R5] [R9]
              exposure_active <= 1'b1;
            end
          end
        end
        FTX_ST_DELAY: begin
          if (exp_done) begin // [R6]
            state_r         <= FTX_ST_EXPOSE;
            cnt_r           <= exp_r;
            exposure_active <= 1'b1;
          end else if (tick) begin
            cnt_r <= cnt_r - 32'h00000001;
          end
        end
        FTX_ST_EXPOSE: begin
          if (exposure_kind_select) begin // [R4]
            // Pulse ends exposure; readout still busy means drop
            if (edge_off) begin // [R18]
              exposure_active <= 1'b0;
              state_r         <= readout_active ? FTX_ST_WAIT : FTX_ST_HOLD; // [R17]
              frame_trig_wait <= readout_active;
            end
          end else if (exp_done) begin
            exposure_active <= 1'b0;
            state_r         <= FTX_ST_HOLD;
          end else if (tick) begin
            cnt_r <= cnt_r - 32'h00000001;
          end
        end
        FTX_ST_HOLD: begin
          // Hand the frame to readout once it is free, then rearm
          if (!readout_active) begin // [R13] [R14] [R15]
            state_r         <= FTX_ST_WAIT;
            frame_trig_wait <= 1'b1;
          end
        end
        default: begin
          state_r         <= FTX_ST_WAIT;
          frame_trig_wait <= 1'b1;
          exposure_active <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Readout timing counted in microsecond ticks, not in system clock cycles

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      readout_active <= 1'b0;
      ro_cnt_r       <= 32'h00000000;
    end else if (state_r == FTX_ST_HOLD && !readout_active) begin
      readout_active <= 1'b1; // [R13]
      ro_cnt_r       <= readout_r;
    end else if (readout_active && tick) begin
      if (ro_cnt_r <= 32'h00000001)
        readout_active <= 1'b0;
      ro_cnt_r <= ro_cnt_r - 32'h00000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error pulses and sticky flags; set wins over a status read clear

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      over_trigger_err <= 1'b0;
      frame_dropped    <= 1'b0;
      ovt_sticky_r     <= 1'b0;
      drop_sticky_r    <= 1'b0;
    end else begin
      over_trigger_err <= (state_r != FTX_ST_WAIT) & edge_on |
                          (state_r == FTX_ST_EXPOSE) & exposure_kind_select &
                          edge_off & readout_active; // [R17] [R19]
      frame_dropped    <= (state_r == FTX_ST_EXPOSE) & exposure_kind_select &
                          edge_off & readout_active; // [R17]
      if (over_trigger_err)
        ovt_sticky_r <= 1'b1;
      else if (reg_rd && reg_addr == FTX_REG_STATUS)
        ovt_sticky_r <= 1'b0;
      if (frame_dropped)
        drop_sticky_r <= 1'b1;
      else if (reg_rd && reg_addr == FTX_REG_STATUS)
        drop_sticky_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_trig_taken;
    state_r == FTX_ST_WAIT && edge_on && delay_r == 32'h00000000;
  endsequence

  chk_wait_drops: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R21]
    s_trig_taken |=> !frame_trig_wait)
    else $error("wait status stayed high after trigger");

  chk_expose_start: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R5]
    s_trig_taken |=> exposure_active && cnt_r == $past(exp_r))
    else $error("exposure did not start with programmed length");

  chk_exp_range: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R10]
    exp_r >= FTX_EXP_MIN_US && exp_r <= FTX_EXP_MAX_US)
    else $error("exposure outside limits");

  chk_ignore_busy: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R19]
    state_r != FTX_ST_WAIT && edge_on |=> over_trigger_err)
    else $error("busy trigger not flagged");

  chk_drop_flag: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R17]
    state_r == FTX_ST_EXPOSE && exposure_kind_select && edge_off && readout_active
    |=> frame_dropped && state_r == FTX_ST_WAIT && !exposure_active)
    else $error("early pulse end not dropped");

  chk_width_end: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R18]
    state_r == FTX_ST_EXPOSE && exposure_kind_select && edge_off |=> !exposure_active)
    else $error("pulse exposure did not end");

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      tick_gap_r <= 8'h00;
    else if (restart || tick)
      tick_gap_r <= {7'h00, ~restart};
    else
      tick_gap_r <= tick_gap_r + 8'h01;
  end
  chk_tick_rate: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R6]
    tick == (tick_gap_r == 8'(FTX_TICK_CYCLES)))
    else $error("microsecond tick period wrong");

  chk_ext_rate: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R7]
    !ctrl_r[FTX_CTL_PERIOD_ON] && state_r == FTX_ST_WAIT && !edge_on |=> state_r == FTX_ST_WAIT)
    else $error("sequencer left wait without a trigger");

  chk_ro_after_exp: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R13]
    $rose(readout_active) |-> $past(state_r) == FTX_ST_HOLD)
    else $error("readout started without exposure");

  chk_delay_clamp: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R20]
    delay_r <= FTX_DELAY_MAX_US)
    else $error("delay above limit");

endmodule

// *** ftx_pkg.sv ***
// Package of constants and types for the frame trigger and exposure controller
package ftx_pkg;

  // Register map (word index on the plain register port)
  localparam logic [3:0] FTX_REG_CTRL     = 4'h0;
  localparam logic [3:0] FTX_REG_EXPOSURE = 4'h1;
  localparam logic [3:0] FTX_REG_DELAY    = 4'h2;
  localparam logic [3:0] FTX_REG_READOUT  = 4'h3;
  localparam logic [3:0] FTX_REG_STATUS   = 4'h4;

  // Control register field positions
  localparam int FTX_CTL_TRIG_EN    = 0;
  localparam int FTX_CTL_SRC_LSB    = 1;
  localparam int FTX_CTL_EDGE_FALL  = 3;
  localparam int FTX_CTL_KIND_WIDTH = 4;
  localparam int FTX_CTL_PERIOD_ON  = 5;
  localparam int FTX_CTL_AUTO_EXP   = 6;

  // Status register field positions
  localparam int FTX_STS_WAIT       = 0;
  localparam int FTX_STS_EXPOSING   = 1;
  localparam int FTX_STS_READING    = 2;
  localparam int FTX_STS_OVERTRIG   = 3;
  localparam int FTX_STS_DROPPED    = 4;

  // Reset values
  localparam logic [31:0] FTX_CTRL_RST     = 32'h00000000;
  localparam logic [31:0] FTX_EXPOSURE_RST = 32'h00000BB8;
  localparam logic [31:0] FTX_DELAY_RST    = 32'h00000000;
  localparam logic [31:0] FTX_READOUT_RST  = 32'h000003E8;

  // Exposure limits and delay limit, in microseconds
  localparam logic [31:0] FTX_EXP_MIN_US   = 32'h00000018;
  localparam logic [31:0] FTX_EXP_MAX_US   = 32'h002625A0;
  localparam logic [31:0] FTX_DELAY_MAX_US = 32'h00989680;

  // Time base
  localparam int FTX_CLK_HZ      = 20000000;
  localparam int FTX_TICK_US     = 1;
  localparam int FTX_TICK_CYCLES = FTX_CLK_HZ / 1000000 * FTX_TICK_US;

  // Trigger source encoding
  typedef enum logic [1:0] {
    FTX_SRC_LINE1 = 2'b00,
    FTX_SRC_CC1   = 2'b01,
    FTX_SRC_CC2   = 2'b10,
    FTX_SRC_CC3   = 2'b11
  } ftx_src_t;

  // Acquisition states
  typedef enum logic [1:0] {
    FTX_ST_WAIT   = 2'b00,
    FTX_ST_DELAY  = 2'b01,
    FTX_ST_EXPOSE = 2'b10,
    FTX_ST_HOLD   = 2'b11
  } ftx_state_t;

endpackage

// *** ftx_us_tick.sv ***
// One microsecond tick generator for the exposure and delay counters
`timescale 1ns/1ps
module ftx_us_tick
  import ftx_pkg::*;
#(
  parameter int DIVIDE = FTX_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Restart aligns the tick with a fresh interval
  input  wire logic restart,
  output logic      tick
);

  logic [7:0] div_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 8'h00;
      tick  <= 1'b0;
    end else if (restart) begin
      div_r <= 8'h00;
      tick  <= 1'b0;
    end else if (div_r == 8'(DIVIDE - 1)) begin
      div_r <= 8'h00;
      tick  <= 1'b1;
    end else begin
      div_r <= div_r + 8'h01;
      tick  <= 1'b0;
    end
  end

endmodule

// *** ftx_trig_src.sv ***
// Trigger source model: frame grabber control lines and the general line
`timescale 1ns/1ps
module ftx_trig_src (
  // Clock
  input  wire logic sys_clk,
  // Line levels seen by the device
  output logic      gp_line_in,
  output logic      cc1_in,
  output logic      cc2_in,
  output logic      cc3_in
);
  logic [3:0] lvl_r;
  logic       idle_r;

  assign {cc3_in, cc2_in, cc1_in, gp_line_in} = lvl_r;

  initial begin
    lvl_r  = 4'h0;
    idle_r = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Park every line at one level; falling-edge use needs the lines idle high
  task automatic park(input logic lv);
    @(posedge sys_clk);
    idle_r <= lv;
    lvl_r  <= {4{lv}};
  endtask

  // Drive one line to its active level or back to idle, just after an edge
  task automatic drive(input int idx, input logic act);
    @(posedge sys_clk);
    lvl_r[idx] <= act ? ~idle_r : idle_r;
  endtask
endmodule

// *** ftx_frame_trig_tb_top.sv ***
// Self-checking bench for the frame trigger and exposure controller
`timescale 1ns/1ps
`define CHK(nm, ev, sv) begin check_count++; if ((sv) !== (ev)) begin error_cnt++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, ev, sv); end end
module ftx_frame_trig_tb_top
  import ftx_pkg::*;
;
  logic        sys_clk, reset_n, reg_wr, reg_rd, gp_line_direction;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  logic        gp_line_in, cc1_in, cc2_in, cc3_in;
  logic        exposure_active, readout_active, frame_trig_wait;
  logic        over_trigger_err, frame_dropped;
  logic [15:0] lfsr_r;
  int          error_cnt, check_count, ot_cnt, fd_cnt, run_len, last_len, n, w, ot0, fd0;
  logic [31:0] rst_tab [6] = '{FTX_CTRL_RST, FTX_EXPOSURE_RST, FTX_DELAY_RST,
                               FTX_READOUT_RST, 32'h00000001, 32'h00000000};

  ftx_frame_trig dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gp_line_in(gp_line_in), .gp_line_direction(gp_line_direction), .cc1_in(cc1_in),
    .cc2_in(cc2_in), .cc3_in(cc3_in), .exposure_active(exposure_active),
    .readout_active(readout_active), .frame_trig_wait(frame_trig_wait),
    .over_trigger_err(over_trigger_err), .frame_dropped(frame_dropped));
  ftx_trig_src src_u (.sys_clk(sys_clk), .gp_line_in(gp_line_in), .cc1_in(cc1_in),
    .cc2_in(cc2_in), .cc3_in(cc3_in));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pulse counters and length of the last exposure, watched every cycle
  always @(posedge sys_clk) begin
    ot_cnt <= ot_cnt + int'(over_trigger_err === 1'b1);
    fd_cnt <= fd_cnt + int'(frame_dropped === 1'b1);
    if (exposure_active === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      run_len  <= 0;
    end
  end

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected exposure register after a write, from the allowed window
  function automatic logic [31:0] exp_clamp(input logic [31:0] v);
    if (v < FTX_EXP_MIN_US)
      return FTX_EXP_MIN_US;
    if (v > FTX_EXP_MAX_US)
      return FTX_EXP_MAX_US;
    return v;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic trig(input int idx, input int len);
    src_u.drive(idx, 1'b1);
    repeat (len) @(posedge sys_clk);
    src_u.drive(idx, 1'b0);
  endtask

  // Skip the cycles before the ready flag drops, then wait a bounded time
  task automatic wait_ready;
    repeat (3) @(posedge sys_clk);
    n = 0;
    while (!(frame_trig_wait === 1'b1 && exposure_active === 1'b0)) begin
      @(posedge sys_clk);
      n++;
      if (n > 60000) begin
        error_cnt++;
        $display("[ERR] ready_wait exp=1 got=0");
        test_done();
      end
    end
  endtask

  initial begin
    #(100000 * 50);
    error_cnt++;
    $display("[ERR] run_time exp=0 got=1");
    test_done();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n           = 1'b0;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    reg_addr          = 4'h0;
    reg_wdata         = 32'h00000000;
    gp_line_direction = 1'b0;
    lfsr_r            = 16'hE052;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    `CHK("wait_rst", 1'b1, frame_trig_wait)
    for (int i = 0; i < 6; i++) begin
      rd(4'(i));
      `CHK("reset_val", rst_tab[i], rd_v)
    end
    $display("[END] reset");
    wr(FTX_REG_EXPOSURE, 32'h00000017);
    rd(FTX_REG_EXPOSURE);
    `CHK("exp_low", exp_clamp(32'h00000017), rd_v)
    wr(FTX_REG_EXPOSURE, 32'hFFFFFFFF);
    rd(FTX_REG_EXPOSURE);
    `CHK("exp_high", exp_clamp(32'hFFFFFFFF), rd_v)
    for (int i = 0; i < 4; i++) begin
      lfsr_r = lfsr_step(lfsr_r);
      wr(FTX_REG_EXPOSURE, 32'(lfsr_r) + FTX_EXP_MIN_US);
      rd(FTX_REG_EXPOSURE);
      `CHK("exp_rand", exp_clamp(32'(lfsr_r) + FTX_EXP_MIN_US), rd_v)
    end
    wr(FTX_REG_DELAY, 32'hFFFFFFFF);
    rd(FTX_REG_DELAY);
    `CHK("delay_high", FTX_DELAY_MAX_US, rd_v)
    wr(FTX_REG_READOUT, 32'h00000000);
    rd(FTX_REG_READOUT);
    `CHK("readout_min", 32'h00000001, rd_v)
    wr(FTX_REG_CTRL, 32'h00000060);
    rd(FTX_REG_CTRL);
    `CHK("ctrl_store", 32'h00000060, rd_v)
    wr(FTX_REG_EXPOSURE, 32'h00000064);
    rd(FTX_REG_EXPOSURE);
    `CHK("exp_auto", 32'(lfsr_r) + FTX_EXP_MIN_US, rd_v)
    wr(FTX_REG_CTRL, 32'h00000000);
    wr(FTX_REG_DELAY, 32'h00000000);
    wr(FTX_REG_EXPOSURE, 32'h00000018);
    $display("[END] registers");
    // Every source in timed mode; the second edge lands mid-exposure
    for (int s = 0; s < 4; s++) begin
      wr(FTX_REG_CTRL, 32'(1 + 2 * s));
      ot0 = ot_cnt;
      trig(s, 3);
      repeat (40) @(posedge sys_clk);
      trig(s, 3);
      wait_ready();
      `CHK("ro_follows", 1'b1, readout_active)
      `CHK("timed_len", 1'b1, last_len >= 460 && last_len <= 500)
      `CHK("ignored_edge", ot0 + 1, ot_cnt)
    end
    $display("[END] timed");
    // Idle level changes only while triggering is off, so no stray edge
    wr(FTX_REG_CTRL, 32'h00000000);
    src_u.park(1'b1);
    wr(FTX_REG_CTRL, 32'h0000000D);
    trig(2, 3);
    wait_ready();
    `CHK("fall_len", 1'b1, last_len >= 460 && last_len <= 500)
    // Falling activation with pulse-length kind: low pulse sets the exposure
    wr(FTX_REG_CTRL, 32'h0000001D);
    trig(2, 30);
    wait_ready();
    `CHK("fall_pulse", 1'b1, last_len >= 30 && last_len <= 33)
    wr(FTX_REG_CTRL, 32'h00000000);
    src_u.park(1'b0);
    $display("[END] falling");
    wr(FTX_REG_DELAY, 32'h00000005);
    wr(FTX_REG_CTRL, 32'h00000003);
    src_u.drive(1, 1'b1);
    for (n = 0; n < 400 && exposure_active !== 1'b1; n++) @(posedge sys_clk);
    `CHK("delay_cyc", 1'b1, n >= 78 && n <= 122)
    src_u.drive(1, 1'b0);
    wait_ready();
    wr(FTX_REG_DELAY, 32'h00000000);
    $display("[END] delay");
    // Unselected line, then line 1 while it is an output
    wr(FTX_REG_CTRL, 32'h00000007);
    trig(1, 3);
    `CHK("unselected", 1'b1, frame_trig_wait & ~exposure_active)
    gp_line_direction <= 1'b1;
    wr(FTX_REG_CTRL, 32'h00000001);
    trig(0, 3);
    `CHK("line_out", 1'b1, frame_trig_wait & ~exposure_active)
    gp_line_direction <= 1'b0;
    $display("[END] no_frame");
    // Long readout so that the second pulse overlaps it and ends too early
    wr(FTX_REG_READOUT, 32'h00000032);
    wr(FTX_REG_CTRL, 32'h00000013);
    lfsr_r = lfsr_step(lfsr_r);
    w = 100 + int'(lfsr_r[7:0]);
    trig(1, w);
    wait_ready();
    `CHK("pulse_len", 1'b1, last_len >= w && last_len <= w + 3)
    ot0 = ot_cnt;
    fd0 = fd_cnt;
    src_u.drive(1, 1'b1);
    repeat (6) @(posedge sys_clk);
    `CHK("overlap", 1'b1, exposure_active & readout_active)
    src_u.drive(1, 1'b0);
    repeat (4) @(posedge sys_clk);
    `CHK("dropped", fd0 + 1, fd_cnt)
    `CHK("over_trig", ot0 + 1, ot_cnt)
    rd(FTX_REG_STATUS);
    `CHK("sticky", 2'b11, rd_v[4:3])
    rd(FTX_REG_STATUS);
    `CHK("sticky_clr", 2'b00, rd_v[4:3])
    $display("[END] pulse");
    test_done();
  end
endmodule
